// [common/abs_pkg.sv]
// Constants, types and the register map for the bias and system control bank.
// Assumes one 40 MHz clock and a plain strobe register port from the serial front end.
// Contract
// - Bit 7 selects bias mid or twelfth level
// - Bias generator off when no input connected
// - Bits 6..0 connect bias to inputs
// - Any combination of bias connections allowed
// - Monitor codes 001 to 100 select measurements
// - Codes 101..111 enable burn-out currents
// - Supply monitors force amplifier gain one
// - Internal monitors open analog input switches
// - Bits 4:3 set calibration sample count
// - Bit 2 enables serial timeout
// - Bit 1 appends CRC byte
// - Bit 0 prepends status byte
// - System control at 09h, reset 10h
package abs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] BIAS_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] SYSCTL_ADDR = 8'h09;
    localparam logic [DATA_W-1:0] BIAS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] SYSCTL_RESET = 8'h10;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
    localparam logic [4:0] CAL_COUNT_1 = 5'h01;
    localparam logic [4:0] CAL_COUNT_4 = 5'h04;
    localparam logic [4:0] CAL_COUNT_8 = 5'h08;
    localparam logic [4:0] CAL_COUNT_16 = 5'h10;

    typedef enum logic [2:0] {
        MON_OFF = 3'h0,
        MON_MID_SHORT = 3'h1,
        MON_TEMP = 3'h2,
        MON_ASUPPLY = 3'h3,
        MON_DSUPPLY = 3'h4,
        MON_BURN_0P2 = 3'h5,
        MON_BURN_1 = 3'h6,
        MON_BURN_10 = 3'h7
    } abs_mon_t;

    typedef enum logic [1:0] {
        BURN_OFF = 2'h0,
        BURN_0P2UA = 2'h1,
        BURN_1UA = 2'h2,
        BURN_10UA = 2'h3
    } abs_burn_t;

    typedef struct packed {
        logic bias_level_select;
        logic bias_to_common_input;
        logic [5:0] bias_to_input;
    } abs_bias_t;

    typedef struct packed {
        abs_mon_t monitor_select;
        logic [1:0] cal_average_count;
        logic timeout_enable;
        logic crc_enable;
        logic prepend_status_enable;
    } abs_sysctl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } abs_req_t;

    typedef struct packed {
        logic bias_enable;
        logic bias_level_select;
        logic bias_to_common_input;
        logic [5:0] bias_to_input;
    } abs_bias_ctl_t;

    typedef struct packed {
        logic [2:0] monitor_mode;
        abs_burn_t burn_current;
        logic force_gain_one;
        logic open_input_switches;
        logic [4:0] cal_samples;
        logic timeout_enable;
        logic crc_enable;
        logic prepend_status_enable;
    } abs_sys_ctl_t;
endpackage

// [rtl/abs_regs.sv]
// Sensor bias and system control register bank with decoded analog controls.
// Assumes the register port is driven from logic on ref_clk_i, so no synchroniser.
module abs_regs (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire abs_pkg::abs_req_t req_i,
    output logic [abs_pkg::DATA_W-1:0] rdata_o,
    output abs_pkg::abs_bias_ctl_t bias_ctl_o,
    output abs_pkg::abs_sys_ctl_t sys_ctl_o
);
    import abs_pkg::*;

    typedef struct packed {
        abs_bias_t bias;
        abs_sysctl_t sysctl;
        logic [DATA_W-1:0] rdata;
        abs_bias_ctl_t bias_ctl;
        abs_sys_ctl_t sys_ctl;
    } abs_state_t;

    abs_state_t st;
    abs_state_t next_st;

    function automatic logic [4:0] cal_count(input logic [1:0] code);
        unique case (code)
            2'h0: cal_count = CAL_COUNT_1;
            2'h1: cal_count = CAL_COUNT_4;
            2'h2: cal_count = CAL_COUNT_8;
            2'h3: cal_count = CAL_COUNT_16;
        endcase
    endfunction

    always_comb begin
        next_st = st;
        if (req_i.wr) begin
            if (req_i.addr == BIAS_ADDR) begin
                next_st.bias = abs_bias_t'(req_i.wdata);
            end
            if (req_i.addr == SYSCTL_ADDR) begin
                next_st.sysctl = abs_sysctl_t'(req_i.wdata);
            end
        end
        if (req_i.rd) begin
            if (req_i.addr == BIAS_ADDR) begin
                next_st.rdata = st.bias;
            end else if (req_i.addr == SYSCTL_ADDR) begin
                next_st.rdata = st.sysctl;
            end else begin
                next_st.rdata = UNMAPPED_READ;
            end
        end
        next_st.bias_ctl.bias_level_select = next_st.bias.bias_level_select;
        next_st.bias_ctl.bias_to_common_input = next_st.bias.bias_to_common_input;
        next_st.bias_ctl.bias_to_input = next_st.bias.bias_to_input;
        next_st.bias_ctl.bias_enable = next_st.bias.bias_to_common_input
            | (|next_st.bias.bias_to_input);
        next_st.sys_ctl.monitor_mode = next_st.sysctl.monitor_select;
        unique case (next_st.sysctl.monitor_select)
            MON_BURN_0P2: next_st.sys_ctl.burn_current = BURN_0P2UA;
            MON_BURN_1: next_st.sys_ctl.burn_current = BURN_1UA;
            MON_BURN_10: next_st.sys_ctl.burn_current = BURN_10UA;
            default: next_st.sys_ctl.burn_current = BURN_OFF;
        endcase
        next_st.sys_ctl.force_gain_one = (next_st.sysctl.monitor_select == MON_ASUPPLY)
            || (next_st.sysctl.monitor_select == MON_DSUPPLY);
        next_st.sys_ctl.open_input_switches = (next_st.sysctl.monitor_select != MON_OFF)
            && (next_st.sysctl.monitor_select <= MON_DSUPPLY);
        next_st.sys_ctl.cal_samples = cal_count(next_st.sysctl.cal_average_count);
        next_st.sys_ctl.timeout_enable = next_st.sysctl.timeout_enable;
        next_st.sys_ctl.crc_enable = next_st.sysctl.crc_enable;
        next_st.sys_ctl.prepend_status_enable = next_st.sysctl.prepend_status_enable;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st.bias <= abs_bias_t'(BIAS_RESET);
            st.sysctl <= abs_sysctl_t'(SYSCTL_RESET);
            st.rdata <= UNMAPPED_READ;
            st.bias_ctl <= '0;
            st.sys_ctl <= '0;
            st.sys_ctl.cal_samples <= CAL_COUNT_8;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign bias_ctl_o = st.bias_ctl;
    assign sys_ctl_o = st.sys_ctl;

    bias_off_empty_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (bias_ctl_o.bias_to_input == '0 && !bias_ctl_o.bias_to_common_input)
        |-> !bias_ctl_o.bias_enable) else $error("bias on without input");
    bias_write_level_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (req_i.wr && req_i.addr == BIAS_ADDR)
        |=> bias_ctl_o.bias_level_select == $past(req_i.wdata[7])) else $error("level");
    bias_write_conn_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (req_i.wr && req_i.addr == BIAS_ADDR) |=> {bias_ctl_o.bias_to_common_input,
        bias_ctl_o.bias_to_input} == $past(req_i.wdata[6:0])) else $error("conn");
    burn_current_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (sys_ctl_o.monitor_mode >= 3'h5)
        == (sys_ctl_o.burn_current != BURN_OFF)) else $error("burn current");
    gain_force_one_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (req_i.wr && req_i.addr == SYSCTL_ADDR && req_i.wdata[7:5] == 3'h3)
        |=> sys_ctl_o.force_gain_one && sys_ctl_o.open_input_switches) else $error("gain");
    switch_open_temp_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (sys_ctl_o.monitor_mode == 3'h2) |-> sys_ctl_o.open_input_switches
        && !sys_ctl_o.force_gain_one) else $error("temp switches");
    cal_samples_map_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (req_i.wr && req_i.addr == SYSCTL_ADDR && req_i.wdata[4:3] == 2'h3)
        |=> sys_ctl_o.cal_samples == CAL_COUNT_16) else $error("cal samples");
    sys_readback_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (req_i.wr && req_i.addr == SYSCTL_ADDR) ##1 (req_i.rd && !req_i.wr
        && req_i.addr == SYSCTL_ADDR) |=> rdata_o == $past(req_i.wdata, 2)) else $error("rb");
    sys_flags_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (req_i.wr && req_i.addr == SYSCTL_ADDR) |=> {sys_ctl_o.timeout_enable,
        sys_ctl_o.crc_enable, sys_ctl_o.prepend_status_enable}
        == $past(req_i.wdata[2:0])) else $error("flags");
endmodule

// [testbench/abs_host.sv]
// Host model: drives the register port of the bias and system control bank.
// Assumes each call starts in the time step of a rising edge; all changes to req_o are non-blocking.
module abs_host (
    input wire logic clk_i,
    input wire logic [abs_pkg::DATA_W-1:0] rdata_i,
    output abs_pkg::abs_req_t req_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import abs_pkg::*;
    initial req_o = '0;
    // One idle edge after each strobe, so no signal is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req_o <= '0;
        @(posedge clk_i);
    endtask
    // Read data stand from the cycle after the strobe and hold until the next read strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        req_o <= '0;
        @(posedge clk_i);
        d = rdata_i;
    endtask
    // Write then read with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
        req_o <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        req_o <= '0;
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule

// [testbench/adc_bias_and_system_control_regs_bench.sv]
// Self-checking bench for the bias and system control register bank.
// Assumes the host model owns the register port; clock 40 MHz.
module adc_bias_and_system_control_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import abs_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    abs_req_t req;
    logic [DATA_W-1:0] rdata;
    abs_bias_ctl_t bias;
    abs_sys_ctl_t system_control;
    int errors = 0;
    int n_tests = 0;
    logic [7:0] d;
    logic [4:0] cal_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
    abs_regs dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .req_i(req), .rdata_o(rdata),
        .bias_ctl_o(bias), .sys_ctl_o(system_control));
    abs_host host (.clk_i(ref_clk), .rdata_i(rdata), .req_o(req));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        host.rd(BIAS_ADDR, d);
        chk("bias reset", 16'(d), 16'h00);
        host.rd(SYSCTL_ADDR, d);
        chk("sys reset", 16'(d), 16'h10);
        chk("cal reset", 16'(system_control.cal_samples), 16'h08);
        $display("test reset done");
        host.wr(BIAS_ADDR, 8'h80);
        #1;
        chk("bias level", 16'(bias.bias_level_select), 16'h1);
        chk("bias off", 16'(bias.bias_enable), 16'h0);
        for (int i = 0; i < 7; i++) begin
            host.wr(BIAS_ADDR, 8'(1 << i));
            #1;
            chk("bias conn", 16'({bias.bias_to_common_input, bias.bias_to_input}),
                16'(1 << i));
            chk("bias on", 16'(bias.bias_enable), 16'h1);
            chk("bias mid", 16'(bias.bias_level_select), 16'h0);
        end
        host.wr(BIAS_ADDR, 8'hff);
        host.rd(BIAS_ADDR, d);
        chk("bias all", 16'({bias.bias_to_common_input, bias.bias_to_input}), 16'h7f);
        chk("bias read", 16'(d), 16'hff);
        $display("test bias done");
        for (int m = 0; m < 8; m++) begin
            // amplifier setup lives outside this bank
            host.wr(SYSCTL_ADDR, {3'(m), 5'h10});
            #1;
            chk("mon mode", 16'(system_control.monitor_mode), 16'(m));
            chk("burn", 16'(system_control.burn_current), (m > 4) ? 16'(m - 4) : 16'h0);
            chk("gain one", 16'(system_control.force_gain_one), 16'(m == 3 || m == 4));
            chk("open sw", 16'(system_control.open_input_switches), 16'(m >= 1 && m <= 4));
        end
        for (int c = 0; c < 4; c++) begin
            host.wr(SYSCTL_ADDR, {3'h0, 2'(c), 3'h0});
            #1;
            chk("cal", 16'(system_control.cal_samples), 16'(cal_tab[c]));
        end
        for (int f = 0; f < 3; f++) begin
            host.wr(SYSCTL_ADDR, 8'(1 << f));
            #1;
            chk("flags", 16'({system_control.timeout_enable, system_control.crc_enable, system_control.prepend_status_enable}),
                16'(1 << f));
        end
        $display("test system done");
        host.wr_rd(SYSCTL_ADDR, 8'hb7, d);
        chk("sys read", 16'(d), 16'hb7);
        host.wr(8'h0a, 8'h5a);
        host.rd(8'h0a, d);
        chk("unmapped", 16'(d), 16'h00);
        host.rd(SYSCTL_ADDR, d);
        chk("sys kept", 16'(d), 16'hb7);
        // Second reset in mid-run
        rst_b <= 1'b0;
        #1;
        chk("cal mid reset", 16'(system_control.cal_samples), 16'h08);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        host.rd(SYSCTL_ADDR, d);
        chk("sys after reset", 16'(d), 16'h10);
        $display("test access done");
        close_out();
    end
endmodule
